/* File: rtl/fault_flag_regs.svh */
// Register offsets, field positions, reset values and timing counts of the fault flag block
`ifndef FAULT_FLAG_REGS_SVH
`define FAULT_FLAG_REGS_SVH

// ***************************************************************
// Register byte offsets
// ***************************************************************
`define OFS_STATUS 8'h00
`define OFS_FLAG_CTL 8'h04
`define OFS_AMP_CUR_CFG 8'h08
`define OFS_AMP_PATH_CTL 8'h0c
`define OFS_PATH_EN 8'h10
`define OFS_LIVE 8'h14

// ***************************************************************
// Field positions
// ***************************************************************
`define BIT_CURRENT 7
`define BIT_THERMAL 6
`define BIT_DIGITAL 4
`define FLAG_BITS 8'hd0
`define BIT_NEG_LIMIT_EN 1
`define BIT_POS_LIMIT_EN 0
`define BIT_THERMAL_LIMIT_DIS 0
`define BIT_TX_EN 0
`define BIT_RX_EN 1

// ***************************************************************
// Reset values
// ***************************************************************
`define RST_STATUS 8'h00
`define RST_FLAG_CTL 8'h00
`define RST_AMP_CUR_CFG 2'h3
`define RST_THERMAL_LIMIT_DIS 1'h0
`define RST_PATH_EN 2'h0

// ***************************************************************
// Timing and thresholds
// ***************************************************************
`define CURRENT_LIMIT_CYCLES 16384
`define TEMP_TRIP_DEGC 165
`define TEMP_RESUME_DEGC 150

`endif

/* File: rtl/fault_flag_pkg.sv */
// Types shared by the fault flag block
package fault_flag_pkg;

	typedef enum logic [1:0] {
		AMP_RUN = 2'h1,
		AMP_HOT = 2'h2
	} amp_state_t;

	typedef struct packed {
		logic [14:0] count;
		logic pulse;
	} limit_timer_t;

	typedef struct packed {
		amp_state_t state;
		logic hot_seen;
		logic amp_allowed;
		logic pulse;
	} thermal_t;

	typedef struct packed {
		logic [7:0] status;
		logic [7:0] flag_ctl;
		logic [1:0] cur_cfg;
		logic thermal_limit_disable;
		logic [1:0] path_en;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic irq;
		logic int_oe;
		logic tx_oe;
		logic rx_oe;
		logic amp_en;
		logic pos_en;
		logic neg_en;
	} ctl_t;

endpackage

/* File: rtl/current_limit_timer.sv */
// Timer that reports a current-limit state lasting too long
`timescale 1ns/100ps
`default_nettype none
`include "fault_flag_regs.svh"
module current_limit_timer
	import fault_flag_pkg::*;
#(
	parameter int LIMIT_CYCLES = `CURRENT_LIMIT_CYCLES
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic clear,
	input wire logic limit_active,
	output logic overload_pulse
);
	limit_timer_t r;
	limit_timer_t next_r;

	// ***************************************************************
	// Counting
	// ***************************************************************
	always_comb begin
		next_r = r;
		next_r.pulse = 1'b0;
		if (clear || !limit_active) begin
			next_r.count = 15'h0000;
		end else begin
			// Fires on the cycle after LIMIT_CYCLES in limit
			next_r.pulse = (r.count == 15'(LIMIT_CYCLES));
			// Saturates so one long fault gives one event
			if (r.count <= 15'(LIMIT_CYCLES)) begin
				next_r.count = r.count + 15'h0001;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign overload_pulse = r.pulse;
endmodule
`default_nettype wire

/* File: rtl/thermal_guard.sv */
// Thermal shutdown with hysteresis for the power amplifier
`timescale 1ns/100ps
`default_nettype none
module thermal_guard
	import fault_flag_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic clear,
	input wire logic over_hot,
	input wire logic cool,
	input wire logic limit_disable,
	output logic amp_allowed,
	output logic overload_pulse
);
	thermal_t r;
	thermal_t next_r;

	// ***************************************************************
	// State machine
	// ***************************************************************
	always_comb begin
		next_r = r;
		next_r.hot_seen = over_hot;
		// Flag event even with the trip disabled
		next_r.pulse = over_hot && !r.hot_seen;
		case (r.state)
			AMP_RUN: begin
				if (over_hot && !limit_disable) begin
					next_r.state = AMP_HOT;
				end
			end
			AMP_HOT: begin
				if (cool || limit_disable) begin
					next_r.state = AMP_RUN;
				end
			end
			default: begin
				next_r.state = AMP_HOT;
			end
		endcase
		if (clear) begin
			next_r.state = AMP_RUN;
			next_r.hot_seen = 1'b0;
			next_r.pulse = 1'b0;
		end
		next_r.amp_allowed = (next_r.state == AMP_RUN);
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			r <= '{state: AMP_RUN, hot_seen: 1'b0, amp_allowed: 1'b1, pulse: 1'b0};
		end else begin
			r <= next_r;
		end
	end

	assign amp_allowed = r.amp_allowed;
	assign overload_pulse = r.pulse;
endmodule
`default_nettype wire

/* File: rtl/fault_flag_interrupt_shutdown.sv */
// Fault flags, interrupt pin, readiness pins and shutdown of the line driver front end
`timescale 1ns/100ps
`default_nettype none
`include "fault_flag_regs.svh"
module fault_flag_interrupt_shutdown
	import fault_flag_pkg::*;
#(
	parameter int LIMIT_CYCLES = `CURRENT_LIMIT_CYCLES
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic shutdown_in,
	input wire logic pos_limit_hit,
	input wire logic neg_limit_hit,
	input wire logic over_hot,
	input wire logic cool,
	input wire logic tx_path_ready,
	input wire logic rx_path_ready,
	output logic irq,
	output logic int_pin_out,
	output logic int_pin_oe,
	output logic tx_flag_out,
	output logic tx_flag_oe,
	output logic rx_flag_out,
	output logic rx_flag_oe,
	output logic amp_out_en,
	output logic pos_current_limit_en,
	output logic neg_current_limit_en
);
	ctl_t r;
	ctl_t next_r;
	logic current_event;
	logic thermal_event;
	logic amp_allowed;
	logic limit_active;

	// ***************************************************************
	// Fault sources
	// ***************************************************************
	// Limit state exists only on sides whose protection is enabled
	assign limit_active = (pos_limit_hit && r.pos_en) || (neg_limit_hit && r.neg_en);

	current_limit_timer #(
		.LIMIT_CYCLES(LIMIT_CYCLES)
	) u_timer (
		.mclk(mclk),
		.rst_b(rst_b),
		.clear(shutdown_in),
		.limit_active(limit_active),
		.overload_pulse(current_event)
	);

	thermal_guard u_thermal (
		.mclk(mclk),
		.rst_b(rst_b),
		.clear(shutdown_in),
		.over_hot(over_hot),
		.cool(cool),
		.limit_disable(r.thermal_limit_disable),
		.amp_allowed(amp_allowed),
		.overload_pulse(thermal_event)
	);

	// ***************************************************************
	// Bus, flags and pins
	// ***************************************************************
	always_comb begin
		logic setup;
		logic access;
		logic mapped;
		logic read_only;
		logic bad;
		logic [7:0] clr;
		logic [7:0] set;
		logic [7:0] live;
		setup = psel && !penable;
		access = psel && penable && r.pready;
		mapped = (paddr == `OFS_STATUS) || (paddr == `OFS_FLAG_CTL) || (paddr == `OFS_AMP_CUR_CFG)
			|| (paddr == `OFS_AMP_PATH_CTL) || (paddr == `OFS_PATH_EN) || (paddr == `OFS_LIVE);
		read_only = (paddr == `OFS_LIVE);
		bad = !mapped || (pwrite && read_only);
		clr = 8'h00;
		set = 8'h00;
		live = {3'h0, r.amp_en, over_hot, limit_active, !r.tx_oe, !r.rx_oe};
		next_r = r;
		next_r.pready = setup;
		if (setup) begin
			next_r.pslverr = bad;
			next_r.prdata = 32'h0000_0000;
			if (!pwrite) begin
				case (paddr)
					`OFS_STATUS: next_r.prdata[7:0] = r.status;
					`OFS_FLAG_CTL: next_r.prdata[7:0] = r.flag_ctl;
					`OFS_AMP_CUR_CFG: next_r.prdata[1:0] = r.cur_cfg;
					`OFS_AMP_PATH_CTL: next_r.prdata[`BIT_THERMAL_LIMIT_DIS] = r.thermal_limit_disable;
					`OFS_PATH_EN: next_r.prdata[1:0] = r.path_en;
					`OFS_LIVE: next_r.prdata[7:0] = live;
					default: next_r.prdata = 32'h0000_0000;
				endcase
			end
		end
		if (access) begin
			if (r.pslverr) begin
				// Bad bus access raises the digital error
				set[`BIT_DIGITAL] = 1'b1;
			end else if (!pwrite && paddr == `OFS_STATUS) begin
				// Only bits actually returned are cleared, so a late event survives
				clr = r.prdata[7:0];
			end else if (pwrite) begin
				case (paddr)
					`OFS_STATUS: clr = pwdata[7:0];
					`OFS_FLAG_CTL: next_r.flag_ctl = pwdata[7:0] & `FLAG_BITS;
					`OFS_AMP_CUR_CFG: next_r.cur_cfg = pwdata[1:0];
					`OFS_AMP_PATH_CTL: next_r.thermal_limit_disable = pwdata[`BIT_THERMAL_LIMIT_DIS];
					`OFS_PATH_EN: next_r.path_en = pwdata[1:0];
					default: clr = 8'h00;
				endcase
			end
		end
		// Flags set regardless of mask
		set[`BIT_CURRENT] = current_event;
		set[`BIT_THERMAL] = thermal_event;
		// Set wins over a clear in the same cycle
		next_r.status = ((r.status & ~clr) | set) & `FLAG_BITS;
		next_r.pos_en = next_r.cur_cfg[`BIT_POS_LIMIT_EN];
		next_r.neg_en = next_r.cur_cfg[`BIT_NEG_LIMIT_EN];
		// Mask bit set means that flag cannot pull the pin
		next_r.irq = |(next_r.status & ~next_r.flag_ctl);
		next_r.int_oe = next_r.irq;
		next_r.amp_en = amp_allowed;
		next_r.tx_oe = !(next_r.path_en[`BIT_TX_EN] && tx_path_ready && amp_allowed);
		next_r.rx_oe = !(next_r.path_en[`BIT_RX_EN] && rx_path_ready);
		if (shutdown_in) begin
			// Everything to defaults except amp_en, which is held off; bus answers with an error so masters never hang
			next_r.status = `RST_STATUS;
			next_r.flag_ctl = `RST_FLAG_CTL;
			next_r.cur_cfg = `RST_AMP_CUR_CFG;
			next_r.thermal_limit_disable = `RST_THERMAL_LIMIT_DIS;
			next_r.path_en = `RST_PATH_EN;
			next_r.prdata = 32'h0000_0000;
			next_r.pslverr = setup;
			next_r.irq = 1'b0;
			next_r.int_oe = 1'b0;
			next_r.tx_oe = 1'b1;
			next_r.rx_oe = 1'b1;
			next_r.amp_en = 1'b0;
			next_r.pos_en = 1'b1;
			next_r.neg_en = 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			r <= '{status: `RST_STATUS, flag_ctl: `RST_FLAG_CTL, cur_cfg: `RST_AMP_CUR_CFG,
				thermal_limit_disable: `RST_THERMAL_LIMIT_DIS, path_en: `RST_PATH_EN, prdata: 32'h0000_0000,
				pready: 1'b0, pslverr: 1'b0, irq: 1'b0, int_oe: 1'b0, tx_oe: 1'b1,
				rx_oe: 1'b1, amp_en: 1'b1, pos_en: 1'b1, neg_en: 1'b1};
		end else begin
			r <= next_r;
		end
	end

	// ***************************************************************
	// Outputs
	// ***************************************************************
	// Open drain pins only ever drive low
	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
	assign irq = r.irq;
	assign int_pin_out = 1'b0;
	assign int_pin_oe = r.int_oe;
	assign tx_flag_out = 1'b0;
	assign tx_flag_oe = r.tx_oe;
	assign rx_flag_out = 1'b0;
	assign rx_flag_oe = r.rx_oe;
	assign amp_out_en = r.amp_en;
	assign pos_current_limit_en = r.pos_en;
	assign neg_current_limit_en = r.neg_en;
endmodule
`default_nettype wire

/* File: bench/fault_flag_checker.sv */
// Port assertions of the fault flag block
`timescale 1ns/100ps
`default_nettype none
`include "fault_flag_regs.svh"
module fault_flag_checker #(
	parameter int LIMIT_CYCLES = `CURRENT_LIMIT_CYCLES
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic shutdown_in,
	input wire logic pos_limit_hit,
	input wire logic neg_limit_hit,
	input wire logic over_hot,
	input wire logic cool,
	input wire logic tx_path_ready,
	input wire logic rx_path_ready,
	input wire logic irq,
	input wire logic int_pin_out,
	input wire logic int_pin_oe,
	input wire logic tx_flag_oe,
	input wire logic rx_flag_oe,
	input wire logic amp_out_en,
	input wire logic pos_current_limit_en,
	input wire logic neg_current_limit_en
);
	// ****
	// Cause window, wide enough for the flag pipeline
	// ****
	logic [15:0] run;
	logic [2:0] since;
	logic act;
	logic hot_d;
	assign act = pos_limit_hit & pos_current_limit_en | neg_limit_hit & neg_current_limit_en;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			run <= '0;
			since <= '0;
			hot_d <= 1'b0;
		end else begin
			hot_d <= over_hot;
			run <= (act && !shutdown_in) ? run + 16'h1 : 16'h0;
			since <= (int'(run) >= LIMIT_CYCLES || over_hot && !hot_d
				|| pready && (pslverr || pwrite && paddr == `OFS_FLAG_CTL)) ? 3'h7
				: since - {2'h0, since != 3'h0};
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	chk_int_tracks_irq: assert property (int_pin_oe == irq)
		else $error("interrupt pin differs from irq");
	chk_int_drives_low: assert property (int_pin_out == 1'b0)
		else $error("interrupt pin drives high");
	chk_irq_has_cause: assert property ($rose(irq) |-> since != 3'h0)
		else $error("interrupt without cause");
	chk_shutdown_parks_all: assert property (shutdown_in |=> !amp_out_en && !irq && tx_flag_oe && rx_flag_oe)
		else $error("shutdown left a block active");
	chk_shutdown_bus_err: assert property (pready && $past(shutdown_in) |-> pslverr)
		else $error("bus answered in shutdown");
	chk_amp_stays_off: assert property (!amp_out_en && !cool && !shutdown_in && !$past(shutdown_in)
		&& !$past(pwrite) |=> !amp_out_en)
		else $error("amplifier back before cooling");
	chk_tx_not_ready: assert property (!$past(tx_path_ready) |-> tx_flag_oe)
		else $error("transmit ready released");
	chk_rx_not_ready: assert property (!$past(rx_path_ready) |-> rx_flag_oe)
		else $error("receive ready released");
	cover property ($rose(irq));
	cover property ($fell(amp_out_en));
	cover property (pready && pslverr);
endmodule
bind fault_flag_interrupt_shutdown fault_flag_checker #(.LIMIT_CYCLES(LIMIT_CYCLES)) fault_flag_checker_i (
	.mclk(mclk), .rst_b(rst_b), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
	.shutdown_in(shutdown_in), .pos_limit_hit(pos_limit_hit), .neg_limit_hit(neg_limit_hit),
	.over_hot(over_hot), .cool(cool), .tx_path_ready(tx_path_ready), .rx_path_ready(rx_path_ready),
	.irq(irq), .int_pin_out(int_pin_out), .int_pin_oe(int_pin_oe), .tx_flag_oe(tx_flag_oe),
	.rx_flag_oe(rx_flag_oe), .amp_out_en(amp_out_en), .pos_current_limit_en(pos_current_limit_en),
	.neg_current_limit_en(neg_current_limit_en));
`default_nettype wire

/* File: bench/line_pullups.sv */
// Board pull-ups seen by the host on the open-drain pins
`timescale 1ns/100ps
`default_nettype none
module line_pullups (
	input wire logic int_pin_out,
	input wire logic int_pin_oe,
	input wire logic tx_flag_out,
	input wire logic tx_flag_oe,
	input wire logic rx_flag_out,
	input wire logic rx_flag_oe,
	output logic int_line,
	output logic tx_line,
	output logic rx_line
);
	assign int_line = int_pin_oe ? int_pin_out : 1'b1;
	assign tx_line = tx_flag_oe ? tx_flag_out : 1'b1;
	assign rx_line = rx_flag_oe ? rx_flag_out : 1'b1;
endmodule
`default_nettype wire

/* File: bench/fault_flag_interrupt_shutdown_tb.sv */
// Self-checking bench of the fault flag block
`timescale 1ns/100ps
`default_nettype none
`include "fault_flag_regs.svh"
module fault_flag_interrupt_shutdown_tb;
	localparam int LIM = 8;
	logic mclk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, shutdown_in = 0, cool = 1;
	logic pos_limit_hit = 0, neg_limit_hit = 0, over_hot = 0, tx_path_ready = 0, rx_path_ready = 0;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, r;
	logic pready, pslverr, irq, int_pin_out, int_pin_oe, tx_flag_out, tx_flag_oe, rx_flag_out, rx_flag_oe;
	logic amp_out_en, pos_current_limit_en, neg_current_limit_en, e, int_line, tx_line, rx_line;
	int n_errors = 0, comparisons = 0, tn = 0;
	always #5 mclk = ~mclk;
	fault_flag_interrupt_shutdown #(.LIMIT_CYCLES(LIM)) fault_flag_interrupt_shutdown_i (.mclk(mclk), .rst_b(rst_b),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .shutdown_in(shutdown_in), .pos_limit_hit(pos_limit_hit),
		.neg_limit_hit(neg_limit_hit), .over_hot(over_hot), .cool(cool), .tx_path_ready(tx_path_ready),
		.rx_path_ready(rx_path_ready), .irq(irq), .int_pin_out(int_pin_out), .int_pin_oe(int_pin_oe),
		.tx_flag_out(tx_flag_out), .tx_flag_oe(tx_flag_oe), .rx_flag_out(rx_flag_out), .rx_flag_oe(rx_flag_oe),
		.amp_out_en(amp_out_en), .pos_current_limit_en(pos_current_limit_en),
		.neg_current_limit_en(neg_current_limit_en));
	line_pullups line_pullups_i (.int_pin_out(int_pin_out), .int_pin_oe(int_pin_oe), .tx_flag_out(tx_flag_out),
		.tx_flag_oe(tx_flag_oe), .rx_flag_out(rx_flag_out), .rx_flag_oe(rx_flag_oe), .int_line(int_line),
		.tx_line(tx_line), .rx_line(rx_line));
	// ****
	// Tasks
	// ****
	task automatic final_report;
		$display("compares %0d errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge mclk);
		penable <= 1'b1;
		// Waits as long as it takes; the watchdog ends a hang
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
		@(posedge mclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		bus(1'b0, a, 32'h0);
		chk(r, x);
	endtask
	task automatic endt;
		$display("test %0d done", tn);
		tn++;
	endtask
	// Random side, so both limit inputs see traffic
	task automatic cur(input int n);
		logic s;
		s = 1'($urandom % 2);
		{pos_limit_hit, neg_limit_hit} <= {s, !s};
		repeat (n) @(posedge mclk);
		{pos_limit_hit, neg_limit_hit} <= 2'b00;
		repeat (5) @(posedge mclk);
	endtask
	task automatic hot;
		{over_hot, cool} <= 2'b10;
		repeat (5) @(posedge mclk);
		chk(amp_out_en, 0);
		over_hot <= 1'b0;
		repeat (3) @(posedge mclk);
		chk(amp_out_en, 0);
		cool <= 1'b1;
		repeat (3) @(posedge mclk);
		chk(amp_out_en, 1);
	endtask
	// ****
	// Tests
	// ****
	initial begin
		repeat (5000) @(posedge mclk);
		n_errors++;
		final_report();
	end
	initial begin
		void'($urandom(57));
		repeat (2) @(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
		rd(`OFS_AMP_CUR_CFG, 32'h3);
		rd(`OFS_STATUS, 32'h0);
		rd(`OFS_LIVE, 32'h10);
		chk({pos_current_limit_en, neg_current_limit_en}, 2'h3);
		chk(int_line, 1);
		cur(LIM);
		rd(`OFS_STATUS, 32'h0);
		endt();
		for (int i = 0; i < 2; i++) begin
			wr(`OFS_FLAG_CTL, i ? 32'hc0 : 32'h0);
			cur(LIM + 3);
			chk(int_line, i);
			rd(`OFS_STATUS, 32'h80);
			chk(int_line, 1);
			hot();
			chk(int_line, i);
			rd(`OFS_STATUS, 32'h40);
			rd(`OFS_STATUS, 32'h0);
			endt();
		end
		bus(1'b1, `OFS_LIVE, 32'hff);
		chk(e, 1);
		wr(`OFS_STATUS, 32'h10);
		chk(irq, 0);
		bus(1'b0, 8'h40, 32'h0);
		chk(e, 1);
		chk(int_line, 0);
		chk(irq, 1);
		rd(`OFS_STATUS, 32'h10);
		wr(`OFS_AMP_CUR_CFG, 32'h0);
		chk({pos_current_limit_en, neg_current_limit_en}, 2'h0);
		cur(LIM + 3);
		rd(`OFS_STATUS, 32'h0);
		wr(`OFS_AMP_PATH_CTL, 32'h1);
		{over_hot, cool} <= 2'b10;
		repeat (5) @(posedge mclk);
		chk(amp_out_en, 1);
		{over_hot, cool} <= 2'b01;
		wr(`OFS_AMP_PATH_CTL, 32'h0);
		rd(`OFS_STATUS, 32'h40);
		endt();
		wr(`OFS_PATH_EN, 32'h3);
		repeat (4) begin
			{tx_path_ready, rx_path_ready} <= 2'($urandom);
			repeat (3) @(posedge mclk);
			chk(tx_line, tx_path_ready);
			chk(rx_line, rx_path_ready);
		end
		endt();
		wr(`OFS_FLAG_CTL, 32'hd0);
		shutdown_in <= 1'b1;
		repeat (3) @(posedge mclk);
		chk(amp_out_en, 0);
		bus(1'b1, `OFS_AMP_CUR_CFG, 32'h0);
		chk(e, 1);
		shutdown_in <= 1'b0;
		@(posedge mclk);
		rd(`OFS_FLAG_CTL, 32'h0);
		rd(`OFS_PATH_EN, 32'h0);
		rd(`OFS_AMP_CUR_CFG, 32'h3);
		wr(`OFS_FLAG_CTL, 32'h0);
		endt();
		final_report();
	end
endmodule
`default_nettype wire
